// file: src/gpd_pkg.sv
// gpd_pkg: constants shared by the gpio pair with debounce and edge interrupts
package gpd_pkg;
  // ==========================================================================
  // geometry
  localparam int PIN_COUNT = 2;
  localparam int FLAG_COUNT = 2 * PIN_COUNT;
  localparam int SYNC_STAGES = 2;
  // ==========================================================================
  // flag and mask layout: rise events low, fall events high
  localparam int RISE_BASE = 0;
  localparam int FALL_BASE = PIN_COUNT;
  // ==========================================================================
  // reset values
  localparam logic [FLAG_COUNT-1:0] MASK_RESET = 4'hf;
  localparam logic [FLAG_COUNT-1:0] FLAG_RESET = 4'h0;
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 2'h0;
  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int BYPASS_MAX_NS = 10;
  localparam int BYPASS_MAX_CYCLES = (BYPASS_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     BYPASS_MAX_NS / CLK_PERIOD_NS;
  localparam int FILTER_PERIOD_MS = 30;
  // filter oscillator rate; plain default, not a measured figure
  localparam int FILTER_OSC_HZ = 32768;
  localparam int FILTER_TICKS = (FILTER_PERIOD_MS * FILTER_OSC_HZ + 999) / 1000;
  localparam int FILTER_CNT_W = $clog2(FILTER_TICKS + 1);
  localparam logic [FILTER_CNT_W-1:0] FILTER_LAST = FILTER_CNT_W'(FILTER_TICKS - 1);
  localparam logic [FILTER_CNT_W-1:0] FILTER_CNT_RESET = '0;
endpackage

// file: src/gpd_ev_if.sv
// gpd_ev_if: filtered pin levels and edge events between the gpio sub-blocks
`timescale 1ns/1ps
interface gpd_ev_if;
  import gpd_pkg::*;
  logic [PIN_COUNT-1:0] level;
  logic [PIN_COUNT-1:0] rise;
  logic [PIN_COUNT-1:0] fall;
  modport filt (output level);
  modport edge_det (input level, output rise, output fall);
  modport core (input level, input rise, input fall);
endinterface

// file: src/gpd_filter.sv
// gpd_filter: per-pin debounce filter timed by the filter oscillator tick
`timescale 1ns/1ps
module gpd_filter
  import gpd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [PIN_COUNT-1:0] sync_level,
  input wire logic [PIN_COUNT-1:0] input_filter_enable,
  input wire logic osc_tick,
  gpd_ev_if.filt ev
);
  logic [PIN_COUNT-1:0] filt_ff;
  logic [PIN_COUNT-1:0] nxt_filt;
  logic [FILTER_CNT_W-1:0] cnt_ff [PIN_COUNT];
  logic [FILTER_CNT_W-1:0] nxt_cnt [PIN_COUNT];

  // ==========================================================================
  // filter per pin
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    always_comb begin
      nxt_filt[i] = filt_ff[i];
      nxt_cnt[i] = cnt_ff[i];
      // disabled filter tracks the pin so enabling it causes no jump
      if (!input_filter_enable[i] || (sync_level[i] == filt_ff[i])) begin
        nxt_filt[i] = sync_level[i];
        nxt_cnt[i] = FILTER_CNT_RESET;
      end else if (osc_tick) begin
        if (cnt_ff[i] == FILTER_LAST) begin
          nxt_filt[i] = sync_level[i];
          nxt_cnt[i] = FILTER_CNT_RESET;
        end else begin
          nxt_cnt[i] = cnt_ff[i] + 1'b1;
        end
      end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        filt_ff[i] <= 1'b0;
        cnt_ff[i] <= FILTER_CNT_RESET;
      end else begin
        filt_ff[i] <= nxt_filt[i];
        cnt_ff[i] <= nxt_cnt[i];
      end
    end

    // bypass passes the synchronised level straight through
    assign ev.level[i] = input_filter_enable[i] ? filt_ff[i] : sync_level[i];
  end
endmodule

// file: src/gpd_edge.sv
// gpd_edge: rising and falling edge detectors on the filtered pin levels
`timescale 1ns/1ps
module gpd_edge
  import gpd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  gpd_ev_if.edge_det ev
);
  logic [PIN_COUNT-1:0] prev_ff;
  logic [PIN_COUNT-1:0] nxt_prev;
  logic [SYNC_STAGES:0] arm_ff;
  logic [SYNC_STAGES:0] nxt_arm;
  logic armed;

  // ==========================================================================
  // history; events wait until synchroniser and history hold post-reset
  // samples, otherwise a pin resting high looks like a rise after reset
  always_comb begin
    nxt_prev = ev.level;
    nxt_arm = {arm_ff[SYNC_STAGES-1:0], 1'b1};
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_ff <= PIN_RESET;
      arm_ff <= '0;
    end else begin
      prev_ff <= nxt_prev;
      arm_ff <= nxt_arm;
    end
  end

  assign armed = arm_ff[SYNC_STAGES];

  // one event per edge: the level is already synchronised, history is one deep
  assign ev.rise = armed ? (ev.level & ~prev_ff) : PIN_RESET;
  assign ev.fall = armed ? (~ev.level & prev_ff) : PIN_RESET;
endmodule

// file: src/gpd_top.sv
// gpd_top: two general-purpose pins with drive styles, debounce and edge interrupt
// Functional notes
// - direction bit clear makes pin an output
// - style one push-pull, zero open-drain
// - input level readable in every direction
// - direction bit set releases pin as input
// - thirty millisecond debounce filter per input
// - filter only while its enable bit is one
// - bypassed input reaches interrupt within ten ns
// - debounce timed by internal filter oscillator
// - separate rising and falling edge events
// - rise mask zero passes, fall mask one blocks
// - rise masked, fall open: falling only
// - both masks clear: both edges interrupt
// - alternate select bit readable per pin
// - pin zero alternate: low-power request input
// - pin one alternate: voltage scaling control
// - low-power request is pin OR register
// - masks reset masked, masked flags silent
`timescale 1ns/1ps
module gpd_top
  import gpd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe,
  input wire logic [PIN_COUNT-1:0] pin_direction,
  input wire logic [PIN_COUNT-1:0] output_style_select,
  input wire logic [PIN_COUNT-1:0] general_output,
  input wire logic [PIN_COUNT-1:0] input_filter_enable,
  input wire logic [PIN_COUNT-1:0] pin_alternate_select,
  output logic [PIN_COUNT-1:0] pin_alternate_status,
  output logic [PIN_COUNT-1:0] pin_input_level,
  input wire logic filter_osc_clk,
  input wire logic low_power_reg_bit,
  output logic bias_low_power_request,
  output logic dynamic_voltage_scaling,
  input wire logic mask_write,
  input wire logic [FLAG_COUNT-1:0] mask_wdata,
  output logic [FLAG_COUNT-1:0] mask_status,
  input wire logic [FLAG_COUNT-1:0] flag_clear,
  output logic [FLAG_COUNT-1:0] flag_status,
  output logic interrupt_request_n
);
  // ==========================================================================
  // synchronisers: pins and the filter oscillator come from outside ref_clk
  logic [PIN_COUNT-1:0] pin_meta_ff;
  logic [PIN_COUNT-1:0] pin_sync_ff;
  logic osc_meta_ff;
  logic osc_sync_ff;
  logic osc_prev_ff;
  logic osc_tick;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_ff <= PIN_RESET;
      pin_sync_ff <= PIN_RESET;
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end else begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
      osc_meta_ff <= filter_osc_clk;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
    end
  end

  // one tick per oscillator period, seen on ref_clk
  assign osc_tick = osc_sync_ff & ~osc_prev_ff;

  // input level ignores direction, so an output can be read back
  assign pin_input_level = pin_sync_ff;

  // ==========================================================================
  // filter and edge detection
  gpd_ev_if ev ();

  gpd_filter u_filter (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sync_level(pin_sync_ff),
    .input_filter_enable(input_filter_enable),
    .osc_tick(osc_tick),
    .ev(ev.filt)
  );

  gpd_edge u_edge (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ev(ev.edge_det)
  );

  // ==========================================================================
  // pin drive
  logic [PIN_COUNT-1:0] out_ff;
  logic [PIN_COUNT-1:0] oe_ff;
  logic [PIN_COUNT-1:0] nxt_out;
  logic [PIN_COUNT-1:0] nxt_oe;

  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      nxt_out[i] = 1'b0;
      nxt_oe[i] = 1'b0;
      // alternate functions are inputs, so the driver stays off there
      if (!pin_direction[i] && !pin_alternate_select[i]) begin
        if (output_style_select[i]) begin
          nxt_out[i] = general_output[i];
          nxt_oe[i] = 1'b1;
        end else begin
          // open-drain: only pull low, release for a high
          nxt_out[i] = 1'b0;
          nxt_oe[i] = ~general_output[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_ff <= PIN_RESET;
      oe_ff <= PIN_RESET;
    end else begin
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
    end
  end

  assign pin_out = out_ff;
  assign pin_oe = oe_ff;

  // ==========================================================================
  // alternate functions
  logic [PIN_COUNT-1:0] alt_ff;
  logic [PIN_COUNT-1:0] nxt_alt;
  logic lpm_ff;
  logic nxt_lpm;
  logic dvs_ff;
  logic nxt_dvs;

  always_comb begin
    nxt_alt = pin_alternate_select;
    nxt_lpm = (pin_alternate_select[0] & ev.level[0]) | low_power_reg_bit;
    nxt_dvs = pin_alternate_select[1] & ev.level[1];
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alt_ff <= PIN_RESET;
      lpm_ff <= 1'b0;
      dvs_ff <= 1'b0;
    end else begin
      alt_ff <= nxt_alt;
      lpm_ff <= nxt_lpm;
      dvs_ff <= nxt_dvs;
    end
  end

  assign pin_alternate_status = alt_ff;
  assign bias_low_power_request = lpm_ff;
  assign dynamic_voltage_scaling = dvs_ff;

  // ==========================================================================
  // interrupt flags and masks
  logic [FLAG_COUNT-1:0] event_vec;
  logic [FLAG_COUNT-1:0] flag_ff;
  logic [FLAG_COUNT-1:0] nxt_flag;
  logic [FLAG_COUNT-1:0] mask_ff;
  logic [FLAG_COUNT-1:0] nxt_mask;

  assign event_vec = {ev.fall, ev.rise};

  always_comb begin
    // a new event beats a clear in the same cycle
    nxt_flag = (flag_ff & ~flag_clear) | event_vec;
    nxt_mask = mask_write ? mask_wdata : mask_ff;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_ff <= FLAG_RESET;
      mask_ff <= MASK_RESET;
    end else begin
      flag_ff <= nxt_flag;
      mask_ff <= nxt_mask;
    end
  end

  assign flag_status = flag_ff;
  assign mask_status = mask_ff;

  // live events are included so an unfiltered edge shows at once
  assign interrupt_request_n = ~|((flag_ff | event_vec) & ~mask_ff);
endmodule

// file: bench/gpd_pin_model.sv
// gpd_pin_model: pads with pull-ups and an outside driver
`timescale 1ns/1ps
module gpd_pin_model
  import gpd_pkg::*;
(
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe,
  input wire logic [PIN_COUNT-1:0] ext_oe,
  input wire logic [PIN_COUNT-1:0] ext_val,
  output logic [PIN_COUNT-1:0] pin_in
);
  // device drive wins; a pad nobody drives rests on its pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe);
endmodule

// file: bench/gpd_top_assertions.sv
// gpd_top_assertions: port checks for the gpio pair
`timescale 1ns/1ps
module gpd_top_assertions
  import gpd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [1:0] pin_in,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic [1:0] pin_direction,
  input wire logic [1:0] output_style_select,
  input wire logic [1:0] general_output,
  input wire logic [1:0] pin_alternate_select,
  input wire logic [1:0] pin_input_level,
  input wire logic [1:0] input_filter_enable,
  input wire logic mask_write,
  input wire logic [3:0] mask_wdata,
  input wire logic [3:0] mask_status,
  input wire logic [3:0] flag_clear,
  input wire logic [3:0] flag_status,
  input wire logic interrupt_request_n
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // ====================
  // sequences
  sequence s_open_rise;
    !input_filter_enable[0] && !mask_status[0] && $rose(pin_in[0]);
  endsequence
  sequence s_held;
    flag_status[0] && !flag_clear[0];
  endsequence
  // ====================
  // properties
  property p_push;
    !pin_direction[0] && !pin_alternate_select[0] && output_style_select[0]
      |=> pin_oe[0] && pin_out[0] == $past(general_output[0]);
  endproperty
  property p_od;
    !pin_direction[1] && !pin_alternate_select[1] && !output_style_select[1]
      |=> !pin_out[1] && pin_oe[1] != $past(general_output[1]);
  endproperty
  // three edges so the synchroniser holds only post-reset samples
  property p_lvl;
    $past(rst_b, 3) |-> pin_input_level == $past(pin_in, 2);
  endproperty
  property p_flag;
    !input_filter_enable[0] && $rose(pin_in[0]) |-> ##[2:4] flag_status[0];
  endproperty
  a_push: assert property (p_push) else $error("push-pull drive");
  a_od: assert property (p_od) else $error("open-drain drive");
  a_rel: assert property (pin_direction[0] |=> !pin_oe[0]) else $error("input driven");
  a_lvl: assert property (p_lvl) else $error("input level");
  a_mask: assert property (mask_write |=> mask_status == $past(mask_wdata))
    else $error("mask load");
  a_silent: assert property (mask_status == MASK_RESET |-> interrupt_request_n)
    else $error("masked irq");
  a_pend: assert property (|(flag_status & ~mask_status) |-> !interrupt_request_n)
    else $error("pending irq");
  a_hold: assert property (s_held |=> flag_status[0]) else $error("flag lost");
  a_byp: assert property (s_open_rise |-> ##[1:3] !interrupt_request_n)
    else $error("bypass irq late");
  a_flag: assert property (p_flag) else $error("rise flag");
endmodule
bind gpd_top gpd_top_assertions chk_u (.ref_clk, .rst_b, .pin_in, .pin_out, .pin_oe,
  .pin_direction, .output_style_select, .general_output, .pin_alternate_select,
  .pin_input_level, .input_filter_enable, .mask_write, .mask_wdata, .mask_status,
  .flag_clear, .flag_status, .interrupt_request_n);

// file: bench/gpd_top_tb.sv
// gpd_top_tb: self-checking bench for the gpio pair
`timescale 1ns/1ps
module gpd_top_tb
  import gpd_pkg::*;
;
  logic ref_clk, rst_b, filter_osc_clk, low_power_reg_bit, mask_write;
  logic bias_low_power_request, dynamic_voltage_scaling, interrupt_request_n;
  logic [1:0] pin_in, pin_out, pin_oe, pin_direction, output_style_select, general_output;
  logic [1:0] input_filter_enable, pin_alternate_select, pin_alternate_status;
  logic [1:0] pin_input_level, ext_oe, ext_val;
  logic [3:0] mask_wdata, mask_status, flag_clear, flag_status;
  logic [3:0] modes [4] = '{4'he, 4'hb, 4'ha, 4'hf};
  logic [31:0] seed = 32'haa02;
  int fail_count = 0;
  int samples_checked = 0;
  gpd_top DUT (.ref_clk, .rst_b, .pin_in, .pin_out, .pin_oe, .pin_direction,
    .output_style_select, .general_output, .input_filter_enable, .pin_alternate_select,
    .pin_alternate_status, .pin_input_level, .filter_osc_clk, .low_power_reg_bit,
    .bias_low_power_request, .dynamic_voltage_scaling, .mask_write, .mask_wdata,
    .mask_status, .flag_clear, .flag_status, .interrupt_request_n);
  gpd_pin_model pads (.pin_out, .pin_oe, .ext_oe, .ext_val, .pin_in);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // odd half period keeps the oscillator out of phase with ref_clk
  initial begin
    filter_osc_clk = 1'b0;
    forever #8.3 filter_osc_clk = ~filter_osc_clk;
  end
  // ====================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] exp_oe();
    return ~pin_direction & (output_style_select | ~general_output);
  endfunction
  function automatic logic [1:0] exp_lvl();
    return (exp_oe() & general_output) | (~exp_oe() & ~(ext_oe & ~ext_val));
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic alt_chk(input logic [7:0] exp);
    chk({pin_alternate_status, pin_oe, 2'h0, bias_low_power_request,
      dynamic_voltage_scaling}, exp);
  endtask
  task automatic pulse(input logic [3:0] m, input logic w);
    mask_wdata = m;
    mask_write = w;
    flag_clear = w ? 4'h0 : 4'hf;
    cyc(1);
    mask_write = 1'b0;
    flag_clear = 4'h0;
    cyc(1);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ====================
  // sequence
  initial begin
    rst_b = 1'b0;
    {pin_direction, output_style_select, general_output, ext_oe, ext_val} = 10'h300;
    {input_filter_enable, pin_alternate_select, low_power_reg_bit, mask_write} = 6'h0;
    {mask_wdata, flag_clear} = 8'h0;
    repeat (16) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    cyc(2);
    chk({mask_status, flag_status}, {MASK_RESET, FLAG_RESET});
    chk({7'h0, interrupt_request_n}, 8'h1);
    cyc(4);
    chk({4'h0, flag_status}, 8'h0);
    repeat (60) begin
      {pin_direction, output_style_select, general_output, ext_oe, ext_val} = 10'(xs());
      cyc(4);
      chk({4'h0, pin_oe, pin_out & pin_oe}, {4'h0, exp_oe(), general_output & exp_oe()});
      chk({5'h0, interrupt_request_n, pin_input_level}, {5'h1, exp_lvl()});
    end
    {pin_direction, ext_oe, ext_val} = 6'h3c;
    cyc(6);
    pulse(4'h0, 1'b0);
    foreach (modes[i]) begin
      pulse(modes[i], 1'b1);
      ext_val[0] = 1'b1;
      cyc(4);
      chk({flag_status, mask_status}, {4'h1, modes[i]});
      chk({7'h0, interrupt_request_n}, {7'h0, modes[i][0]});
      ext_val[0] = 1'b0;
      cyc(4);
      chk({flag_status, 3'h0, interrupt_request_n}, {4'h5, 3'h0, modes[i][0] & modes[i][2]});
      pulse(4'h0, 1'b0);
    end
    {pin_alternate_select, pin_direction, output_style_select, ext_val} = 8'hc3;
    cyc(4);
    alt_chk(8'hc3);
    {low_power_reg_bit, ext_val} = 3'h4;
    cyc(4);
    alt_chk(8'hc2);
    low_power_reg_bit = 1'b0;
    cyc(4);
    alt_chk(8'hc0);
    {pin_alternate_select, pin_direction, input_filter_enable} = 6'h0e;
    cyc(10);
    pulse(4'h0, 1'b0);
    pulse(4'hd, 1'b1);
    ext_val[1] = 1'b1;
    cyc(200);
    ext_val[1] = 1'b0;
    cyc(8);
    chk({4'h0, flag_status}, 8'h0);
    ext_val[1] = 1'b1;
    cyc(2000);
    chk({7'h0, interrupt_request_n}, 8'h1);
    cyc(2400);
    chk({flag_status, 3'h0, interrupt_request_n}, 8'h20);
    wrap_up();
  end
  // the whole sequence needs about 20 us
  initial begin
    #40000;
    fail_count++;
    wrap_up();
  end
endmodule
